// >>> common/nfcs_pkg.sv
/*
 * Shared constants and types of the stream and transparent codec.
 * Assumes a carrier clock (fc) for the link side and a system clock for the host side.
 */
`default_nettype none

package nfcs_pkg;

   // Stream mode selection.
   typedef enum logic [1:0] {NFCS_STRM_OFF, NFCS_STRM_SUBC, NFCS_STRM_BPSK} nfcs_strm_e;

   localparam int           TUNE_W         = 4;
   localparam int           OPC_W          = 8;
   localparam int           BYTE_W         = 8;

   // Sub-carrier dividers in carrier cycles, shifted right by the frequency select.
   localparam logic [6:0]   SUBC_DIV_BASE  = 7'h40;
   localparam logic [6:0]   BPSK_DIV_BASE  = 7'h10;
   localparam logic [6:0]   BPSK_DIV_MIN   = 7'h04;
   localparam logic [3:0]   SUBC_PER_MIN   = 4'h2;
   localparam logic [3:0]   SUBC_QUIET_MAX = 4'h8;
   // Transmit bit period in carrier cycles for a select value of zero.
   localparam logic [7:0]   TX_BIT_BASE    = 8'h80;

   // Pin synchroniser lanes on the system clock.
   localparam int           NPIN           = 6;
   localparam int           PIN_SS         = 0;
   localparam int           PIN_MOSI       = 1;
   localparam int           PIN_SCLK       = 2;
   localparam int           PIN_AM         = 3;
   localparam int           PIN_PM         = 4;
   localparam int           PIN_FD         = 5;

   // Event toggles from the carrier domain.
   localparam int           NEV            = 4;
   localparam int           EV_START       = 0;
   localparam int           EV_BYTE        = 1;
   localparam int           EV_END         = 2;
   localparam int           EV_DONE        = 3;

   localparam int           CFG_W          = 10;

endpackage : nfcs_pkg

`default_nettype wire

// >>> rtl/nfcs_stream_codec.sv
/*
 * Antenna tuning switch drive, transparent mode pin routing and stream mode codec.
 * Assumes SPI command decoding outside, delivering one-cycle command pulses on i_clk,
 * and digitized demodulator outputs arriving asynchronously.
 */
//
// Contract
// RL1 - Manual select drives tuning switches from bits.
// RL2 - Same-weight switches of both groups move together.
// RL3 - Transparent entered on slave select rise, held high.
// RL4 - Host powers and configures front end first.
// RL5 - MOSI level gates modulator, high is on.
// RL6 - SCLK level drives receive enable.
// RL7 - AM output to MISO, PM to interrupt.
// RL8 - Single channel goes to MISO, interrupt low.
// RL9 - Transparent ignores protocol, framing and FIFO settings.
// RL10 - Any SPI command leaves transparent mode.
// RL11 - Field detect routed to interrupt when enabled.
// RL12 - Field detect with idle control: low-power target.
// RL13 - First stream bit lands in byte LSB.
// RL14 - Stream mode and options from separate settings.
// RL15 - Sub-carrier fc/64 to fc/8, two to eight periods.
// RL16 - Sub-carrier bit: one detected, zero quiet.
// RL17 - Sub-carrier ends after over eight quiet periods.
// RL18 - Sub-carrier 01b gives fc/32, 10b four periods.
// RL19 - BPSK fc/16 to fc/4, one to eight periods.
// RL20 - BPSK bit zero same phase, one inverted.
// RL21 - BPSK ends at first quiet period.
// RL22 - BPSK 01b gives fc/8, 01b two periods.
// RL23 - Transmit bit one modulates for one bit period.
// RL24 - Stream transmit starts only on transmit command.
// RL25 - Transmit select 000b gives 128 carrier cycles.
`default_nettype none

module nfcs_stream_codec (
   // Clocks and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_fc_clk,
   input  wire logic                          i_sys_rst,
   // Antenna tuning
   input  wire logic                          i_tune_manual,
   input  wire logic [nfcs_pkg::TUNE_W-1:0]   i_tune_bits,
   input  wire logic [nfcs_pkg::TUNE_W-1:0]   i_tune_auto,
   output logic      [nfcs_pkg::TUNE_W-1:0]   o_tune_cap_switch_pin1,
   output logic      [nfcs_pkg::TUNE_W-1:0]   o_tune_cap_switch_pin2,
   // Commands from the SPI decoder
   input  wire logic                          i_cmd_start,
   input  wire logic                          i_cmd_transparent,
   input  wire logic                          i_tx_cmd,
   // SPI and analog pins
   input  wire logic                          i_spi_ss,
   input  wire logic                          i_spi_mosi,
   input  wire logic                          i_spi_sclk,
   input  wire logic                          i_demod_am,
   input  wire logic                          i_demod_pm,
   input  wire logic                          i_field_det,
   // Configuration
   input  wire logic                          i_rx_chan_am_en,
   input  wire logic                          i_rx_chan_pm_en,
   input  wire logic                          i_field_detect_enable,
   input  wire logic [nfcs_pkg::OPC_W-1:0]    i_op_ctrl,
   input  wire nfcs_pkg::nfcs_strm_e          i_stream_mode,
   input  wire logic [1:0]                    i_scf,
   input  wire logic [1:0]                    i_scp,
   input  wire logic [2:0]                    i_stx,
   // Normal-mode sources of the shared pins
   input  wire logic                          i_rx_on_norm,
   input  wire logic                          i_miso_norm,
   input  wire logic                          i_irq_norm,
   // Pin and front-end outputs
   output logic                               o_transparent,
   output logic                               o_low_power_target,
   output logic                               o_rx_on,
   output logic                               o_spi_miso,
   output logic                               o_irq,
   output logic                               o_tx_mod,
   // Stream data to and from the FIFO side
   input  wire logic [nfcs_pkg::BYTE_W-1:0]   i_tx_byte,
   input  wire logic                          i_tx_byte_valid,
   output logic                               o_tx_byte_ready,
   output logic                               o_tx_done,
   output logic      [nfcs_pkg::BYTE_W-1:0]   o_rx_byte,
   output logic                               o_rx_byte_valid,
   output logic                               o_rx_start,
   output logic                               o_rx_end
);
   import nfcs_pkg::*;

   typedef enum logic {NFCS_RX_IDLE, NFCS_RX_RUN} nfcs_rx_e;
   typedef enum logic {NFCS_TX_IDLE, NFCS_TX_RUN} nfcs_tx_e;

   logic [NPIN-1:0]  pin_raw;
   logic [NPIN-1:0]  pin_s1_reg;
   logic [NPIN-1:0]  pin_s2_reg;
   logic             ss_d_reg;
   logic             ss_rise;
   logic             tm_arm_reg;
   logic             tm_reg;
   logic [NEV-1:0]   ev_tgl;
   logic [NEV-1:0]   ev_s1_reg;
   logic [NEV-1:0]   ev_s2_reg;
   logic [NEV-1:0]   ev_s3_reg;
   logic [NEV-1:0]   ev_pulse;
   logic             ack_s1_reg;
   logic             ack_s2_reg;
   logic             tx_arm_reg;
   logic             req_tgl_reg;
   logic [BYTE_W-1:0] tx_hold_reg;
   logic [BYTE_W-1:0] rx_byte_reg;
   logic             tx_ack_tgl_reg;

   assign pin_raw = {i_field_det, i_demod_pm, i_demod_am, i_spi_sclk, i_spi_mosi, i_spi_ss};
   assign ss_rise = pin_s2_reg[PIN_SS] & ~ss_d_reg;
   assign o_transparent = tm_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         ss_d_reg   <= 1'b0;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         ss_d_reg   <= pin_s2_reg[PIN_SS];
      end
   end

   // RL1 RL2 tuning switch drive
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_tune_cap_switch_pin1 <= '0;
         o_tune_cap_switch_pin2 <= '0;
      end
      else
      begin
         o_tune_cap_switch_pin1 <= i_tune_manual ? i_tune_bits : i_tune_auto;
         o_tune_cap_switch_pin2 <= i_tune_manual ? i_tune_bits : i_tune_auto;
      end
   end

   // RL3 RL10 transparent entry and exit
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tm_arm_reg <= 1'b0;
         tm_reg     <= 1'b0;
      end
      else
      begin
         if (i_cmd_transparent)
            tm_arm_reg <= 1'b1;
         else if (i_cmd_start || ss_rise)
            tm_arm_reg <= 1'b0;
         if (ss_rise && tm_arm_reg)
            tm_reg <= 1'b1;
         else if (!pin_s2_reg[PIN_SS] || i_cmd_start)
            tm_reg <= 1'b0;
      end
   end

   // RL6 RL7 RL8 RL11 RL12 pin routing
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rx_on            <= 1'b0;
         o_spi_miso         <= 1'b0;
         o_irq              <= 1'b0;
         o_low_power_target <= 1'b0;
      end
      else
      begin
         o_low_power_target <= i_field_detect_enable && (i_op_ctrl == '0);
         if (tm_reg)
         begin
            o_rx_on    <= pin_s2_reg[PIN_SCLK];
            o_spi_miso <= i_rx_chan_am_en ? pin_s2_reg[PIN_AM] :
                          (i_rx_chan_pm_en & pin_s2_reg[PIN_PM]);
            if (i_field_detect_enable)
               o_irq <= pin_s2_reg[PIN_FD];
            else
               o_irq <= i_rx_chan_am_en & i_rx_chan_pm_en & pin_s2_reg[PIN_PM];
         end
         else
         begin
            o_rx_on    <= i_rx_on_norm;
            o_spi_miso <= i_miso_norm;
            o_irq      <= i_irq_norm;
         end
      end
   end

   // Events cross as toggles; each one stays put for many carrier cycles.
   assign ev_pulse = ev_s2_reg ^ ev_s3_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ev_s1_reg  <= '0;
         ev_s2_reg  <= '0;
         ev_s3_reg  <= '0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end
      else
      begin
         ev_s1_reg  <= ev_tgl;
         ev_s2_reg  <= ev_s1_reg;
         ev_s3_reg  <= ev_s2_reg;
         ack_s1_reg <= tx_ack_tgl_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   // The received byte is stable for at least eight carrier cycles after its toggle.
   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rx_byte       <= '0;
         o_rx_byte_valid <= 1'b0;
         o_rx_start      <= 1'b0;
         o_rx_end        <= 1'b0;
         o_tx_done       <= 1'b0;
      end
      else
      begin
         if (ev_pulse[EV_BYTE])
            o_rx_byte <= rx_byte_reg;
         o_rx_byte_valid <= ev_pulse[EV_BYTE];
         o_rx_start      <= ev_pulse[EV_START];
         o_rx_end        <= ev_pulse[EV_END];
         o_tx_done       <= ev_pulse[EV_DONE];
      end
   end

   // RL24 transmit arming
   assign o_tx_byte_ready = tx_arm_reg && (req_tgl_reg == ack_s2_reg);

   always_ff @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_arm_reg  <= 1'b0;
         req_tgl_reg <= 1'b0;
         tx_hold_reg <= '0;
      end
      else
      begin
         if (i_tx_cmd)
            tx_arm_reg <= 1'b1;
         else if (ev_pulse[EV_DONE])
            tx_arm_reg <= 1'b0;
         if (i_tx_byte_valid && o_tx_byte_ready)
         begin
            tx_hold_reg <= i_tx_byte;
            req_tgl_reg <= ~req_tgl_reg;
         end
      end
   end

   // Carrier domain. Settings are quasi-static and change only while streaming is idle.
   logic [CFG_W-1:0] cfg_s1_reg;
   logic [CFG_W-1:0] cfg_s2_reg;
   logic             tm_f;
   nfcs_strm_e       mode_f;
   logic [1:0]       scf_f;
   logic [1:0]       scp_f;
   logic [2:0]       stx_f;
   logic             mosi_f1_reg;
   logic             mosi_f2_reg;
   logic             am_f1_reg;
   logic             am_f2_reg;
   logic             am_f3_reg;
   logic             req_s1_reg;
   logic             req_s2_reg;
   logic             active;
   logic [6:0]       sc_div;
   logic [3:0]       per_num;
   logic [3:0]       det_min;
   logic             sc_last;
   logic             per_end;
   logic             det;
   logic [6:0]       sc_cnt_reg;
   logic [3:0]       per_cnt_reg;
   logic [3:0]       edge_cnt_reg;
   logic             samp_reg;
   logic             ref_reg;
   nfcs_rx_e         rx_st_reg;
   logic [3:0]       quiet_reg;
   logic             push;
   logic             push_bit;
   logic             rx_go;
   logic             rx_fin;
   logic [BYTE_W-1:0] rx_sh_reg;
   logic [2:0]       rx_bits_reg;
   logic             start_tgl_reg;
   logic             byte_tgl_reg;
   logic             end_tgl_reg;
   logic             done_tgl_reg;
   nfcs_tx_e         tx_st_reg;
   logic [BYTE_W-1:0] tx_sh_reg;
   logic [2:0]       tx_idx_reg;
   logic [7:0]       bt_cnt_reg;
   logic [7:0]       tx_len;
   logic             bit_end;
   logic             tx_load;

   assign ev_tgl = {done_tgl_reg, end_tgl_reg, byte_tgl_reg, start_tgl_reg};
   assign tm_f   = cfg_s2_reg[9];
   assign mode_f = nfcs_strm_e'(cfg_s2_reg[8:7]);
   assign scf_f  = cfg_s2_reg[6:5];
   assign scp_f  = cfg_s2_reg[4:3];
   assign stx_f  = cfg_s2_reg[2:0];

   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cfg_s1_reg  <= '0;
         cfg_s2_reg  <= '0;
         mosi_f1_reg <= 1'b0;
         mosi_f2_reg <= 1'b0;
         am_f1_reg   <= 1'b0;
         am_f2_reg   <= 1'b0;
         am_f3_reg   <= 1'b0;
         req_s1_reg  <= 1'b0;
         req_s2_reg  <= 1'b0;
      end
      else
      begin
         cfg_s1_reg  <= {tm_reg, i_stream_mode, i_scf, i_scp, i_stx};
         cfg_s2_reg  <= cfg_s1_reg;
         mosi_f1_reg <= i_spi_mosi;
         mosi_f2_reg <= mosi_f1_reg;
         am_f1_reg   <= i_demod_am;
         am_f2_reg   <= am_f1_reg;
         am_f3_reg   <= am_f2_reg;
         req_s1_reg  <= req_tgl_reg;
         req_s2_reg  <= req_s1_reg;
      end
   end

   // RL9 RL14 RL15 RL18 RL19 RL22 reporting period timing
   always_comb
   begin
      active = !tm_f && (mode_f != NFCS_STRM_OFF);
      if (mode_f == NFCS_STRM_BPSK)
         sc_div = (scf_f == 2'h3) ? BPSK_DIV_MIN : (BPSK_DIV_BASE >> scf_f);
      else
         sc_div = SUBC_DIV_BASE >> scf_f;
      if (mode_f == NFCS_STRM_SUBC && scp_f == 2'h0)
         per_num = SUBC_PER_MIN;
      else
         per_num = 4'h1 << scp_f;
      det_min = (mode_f == NFCS_STRM_SUBC) ? (per_num >> 1) : 4'h1;
      sc_last = (sc_cnt_reg == sc_div - 7'h01);
      per_end = sc_last && (per_cnt_reg == per_num - 4'h1);
      det     = (edge_cnt_reg >= det_min);
   end

   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         sc_cnt_reg   <= '0;
         per_cnt_reg  <= '0;
         edge_cnt_reg <= '0;
         samp_reg     <= 1'b0;
      end
      else
      begin
         sc_cnt_reg  <= (!active || sc_last) ? 7'h00 : sc_cnt_reg + 7'h01;
         per_cnt_reg <= (!active || per_end) ? 4'h0 :
                        (sc_last ? per_cnt_reg + 4'h1 : per_cnt_reg);
         if (!active || per_end)
            edge_cnt_reg <= '0;
         else if (am_f2_reg && !am_f3_reg && edge_cnt_reg != 4'hF)
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
         if (per_cnt_reg == 4'h0 && sc_cnt_reg == (sc_div >> 2))
            samp_reg <= am_f2_reg;
      end
   end

   // RL16 RL17 RL20 RL21 reporting period coding
   always_comb
   begin
      push     = 1'b0;
      push_bit = 1'b0;
      rx_go    = 1'b0;
      rx_fin   = 1'b0;
      if (active && per_end)
      begin
         unique case (rx_st_reg)
            NFCS_RX_IDLE:
            begin
               rx_go    = det;
               push     = det;
               push_bit = det && (mode_f == NFCS_STRM_SUBC);
            end
            NFCS_RX_RUN:
            begin
               rx_fin   = !det && (mode_f == NFCS_STRM_BPSK || quiet_reg == SUBC_QUIET_MAX);
               push     = !rx_fin;
               push_bit = (mode_f == NFCS_STRM_SUBC) ? det : (samp_reg ^ ref_reg);
            end
         endcase
      end
   end

   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_st_reg     <= NFCS_RX_IDLE;
         quiet_reg     <= '0;
         ref_reg       <= 1'b0;
         start_tgl_reg <= 1'b0;
         end_tgl_reg   <= 1'b0;
      end
      else
      begin
         if (!active || rx_fin)
            rx_st_reg <= NFCS_RX_IDLE;
         else if (rx_go)
            rx_st_reg <= NFCS_RX_RUN;
         if (rx_go)
            ref_reg <= samp_reg;
         if (rx_go || (per_end && det))
            quiet_reg <= '0;
         else if (per_end && quiet_reg != 4'hF)
            quiet_reg <= quiet_reg + 4'h1;
         if (rx_go)
            start_tgl_reg <= ~start_tgl_reg;
         if (rx_fin)
            end_tgl_reg <= ~end_tgl_reg;
      end
   end

   // RL13 bits fill each byte from its LSB
   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_sh_reg    <= '0;
         rx_byte_reg  <= '0;
         rx_bits_reg  <= '0;
         byte_tgl_reg <= 1'b0;
      end
      else if (push)
      begin
         rx_sh_reg   <= {push_bit, rx_sh_reg[7:1]};
         rx_bits_reg <= rx_bits_reg + 3'h1;
         if (rx_bits_reg == 3'h7)
         begin
            rx_byte_reg  <= {push_bit, rx_sh_reg[7:1]};
            byte_tgl_reg <= ~byte_tgl_reg;
         end
      end
      else if (rx_fin || !active)
      begin
         rx_bits_reg <= '0;
         if (rx_fin && rx_bits_reg != 3'h0)
         begin
            rx_byte_reg  <= rx_sh_reg >> (4'h8 - {1'b0, rx_bits_reg});
            byte_tgl_reg <= ~byte_tgl_reg;
         end
      end
   end

   // RL25 transmit bit period
   assign tx_len  = TX_BIT_BASE >> stx_f;
   assign bit_end = (bt_cnt_reg == tx_len - 8'h01);
   // RL24 bytes start a run only after the command armed the host side
   assign tx_load = active && (req_s2_reg != tx_ack_tgl_reg) &&
                    (tx_st_reg == NFCS_TX_IDLE || (bit_end && tx_idx_reg == 3'h7));

   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_st_reg      <= NFCS_TX_IDLE;
         tx_sh_reg      <= '0;
         tx_idx_reg     <= '0;
         bt_cnt_reg     <= '0;
         tx_ack_tgl_reg <= 1'b0;
         done_tgl_reg   <= 1'b0;
      end
      else if (tx_load)
      begin
         tx_sh_reg      <= tx_hold_reg;
         tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
         tx_idx_reg     <= '0;
         bt_cnt_reg     <= '0;
         tx_st_reg      <= NFCS_TX_RUN;
      end
      else if (tx_st_reg == NFCS_TX_RUN)
      begin
         bt_cnt_reg <= bit_end ? 8'h00 : bt_cnt_reg + 8'h01;
         if (!active || (bit_end && tx_idx_reg == 3'h7))
         begin
            tx_st_reg    <= NFCS_TX_IDLE;
            done_tgl_reg <= ~done_tgl_reg;
         end
         else if (bit_end)
         begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
            tx_sh_reg  <= tx_sh_reg >> 1;
         end
      end
   end

   // RL5 RL23 modulator source
   always_ff @(posedge i_fc_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_tx_mod <= 1'b0;
      else
         o_tx_mod <= tm_f ? mosi_f2_reg : ((tx_st_reg == NFCS_TX_RUN) && tx_sh_reg[0]);
   end

   a_tune_manual: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL1
      i_tune_manual |=> o_tune_cap_switch_pin1 == $past(i_tune_bits))
      else $error("Manual tuning bits not applied.");
   a_tune_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL2
      o_tune_cap_switch_pin1 == o_tune_cap_switch_pin2)
      else $error("Tuning switch pair differs.");
   a_tm_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL3
      ss_rise && tm_arm_reg && !i_cmd_start |=> tm_reg)
      else $error("Transparent mode not entered.");
   a_tm_exit: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL10
      tm_reg && (i_cmd_start || !pin_s2_reg[PIN_SS]) |=> !tm_reg)
      else $error("Transparent mode not left.");
   a_sclk_rx_on: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL6
      tm_reg |=> o_rx_on == $past(pin_s2_reg[PIN_SCLK]))
      else $error("Receive enable not from SCLK.");
   a_single_chan: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL8
      tm_reg && !i_field_detect_enable && !(i_rx_chan_am_en && i_rx_chan_pm_en) |=> !o_irq)
      else $error("Interrupt not low with one channel.");
   a_fd_route: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL11
      tm_reg && i_field_detect_enable |=> o_irq == $past(pin_s2_reg[PIN_FD]))
      else $error("Field detect not on interrupt.");
   a_lp_target: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RL12
      i_field_detect_enable && i_op_ctrl == '0 |=> o_low_power_target)
      else $error("Low-power target not entered.");
   a_subc_end: assert property (@(posedge i_fc_clk) disable iff (i_sys_rst) // RL17
      rx_st_reg == NFCS_RX_RUN && mode_f == NFCS_STRM_SUBC && active && per_end && !det
      && quiet_reg < SUBC_QUIET_MAX |-> !rx_fin)
      else $error("Sub-carrier reception ended early.");
   a_bpsk_end: assert property (@(posedge i_fc_clk) disable iff (i_sys_rst) // RL21
      rx_st_reg == NFCS_RX_RUN && mode_f == NFCS_STRM_BPSK && active && per_end && !det
      |=> rx_st_reg == NFCS_RX_IDLE)
      else $error("BPSK reception did not end.");
   a_tx_mod: assert property (@(posedge i_fc_clk) disable iff (i_sys_rst) // RL23
      !tm_f && tx_st_reg == NFCS_TX_RUN |=> o_tx_mod == $past(tx_sh_reg[0]))
      else $error("Modulation does not follow bit.");

   c_tm_entered: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(tm_reg));
   c_rx_start: cover property (@(posedge i_fc_clk) disable iff (i_sys_rst) rx_go);
   c_rx_end: cover property (@(posedge i_fc_clk) disable iff (i_sys_rst) rx_fin);
   c_tx_run: cover property (@(posedge i_fc_clk) disable iff (i_sys_rst) tx_load);

endmodule : nfcs_stream_codec

`default_nettype wire

// >>> tb/nfcs_host_model.sv
/* Host pin model driving slave select, data and clock pins of the serial port.
   Assumes the bench calls set_pins from the system clock domain after configuring. */
`default_nettype none
module nfcs_host_model (
   // Clock and pins
   input  wire logic i_clk,
   output var  logic o_ss,
   output var  logic o_mosi,
   output var  logic o_sclk
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      o_ss   = 1'b0;
      o_mosi = 1'b0;
      o_sclk = 1'b0;
   end
   task automatic set_pins(input logic ss, input logic mosi, input logic sclk);
      @(posedge i_clk);
      #1;
      o_ss   = ss;
      o_mosi = mosi;
      o_sclk = sclk;
   endtask : set_pins
endmodule : nfcs_host_model
`default_nettype wire

// >>> tb/nfc_stream_transparent_mode_bench.sv
/* Bench of the tuning and transparent routing of the codec.
   Assumes the codec and the host pin model are compiled before it. */
`default_nettype none
module nfc_stream_transparent_mode_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import nfcs_pkg::*;
   logic i_clk=0, i_fc_clk=0, i_sys_rst=1, i_tune_manual=0, i_cmd_start=0, i_tx_cmd=0;
   logic i_cmd_transparent=0, i_demod_am=0, i_demod_pm=0, i_field_det=0;
   logic i_rx_chan_am_en=1, i_rx_chan_pm_en=1, i_field_detect_enable=0, i_tx_byte_valid=0;
   logic i_rx_on_norm=0, i_miso_norm=0, i_irq_norm=0;
   logic [3:0] i_tune_bits=4'h0, i_tune_auto=4'h5, o_tune_cap_switch_pin1, o_tune_cap_switch_pin2;
   logic [7:0] i_op_ctrl=8'h01, i_tx_byte=8'h00, o_rx_byte;
   logic [1:0] i_scf=2'h0, i_scp=2'h0;
   logic [2:0] i_stx=3'h0;
   nfcs_strm_e i_stream_mode = NFCS_STRM_OFF;
   logic i_spi_ss, i_spi_mosi, i_spi_sclk, o_transparent, o_low_power_target, o_rx_on;
   logic o_spi_miso, o_irq, o_tx_mod, o_tx_byte_ready, o_tx_done, o_rx_byte_valid;
   logic o_rx_start, o_rx_end;
   logic [2:0] rx_seen = 3'h0;
   int fail_count = 0, n_checks = 0, cyc = 0, k = 0;
   nfcs_host_model nfcs_host_model_i (.i_clk, .o_ss(i_spi_ss), .o_mosi(i_spi_mosi),
      .o_sclk(i_spi_sclk));
   nfcs_stream_codec nfcs_stream_codec_i (.i_clk, .i_fc_clk, .i_sys_rst, .i_tune_manual,
      .i_tune_bits, .i_tune_auto, .o_tune_cap_switch_pin1, .o_tune_cap_switch_pin2,
      .i_cmd_start, .i_cmd_transparent, .i_tx_cmd, .i_spi_ss, .i_spi_mosi, .i_spi_sclk,
      .i_demod_am, .i_demod_pm, .i_field_det, .i_rx_chan_am_en, .i_rx_chan_pm_en,
      .i_field_detect_enable, .i_op_ctrl, .i_stream_mode, .i_scf, .i_scp, .i_stx,
      .i_rx_on_norm, .i_miso_norm, .i_irq_norm, .o_transparent, .o_low_power_target,
      .o_rx_on, .o_spi_miso, .o_irq, .o_tx_mod, .i_tx_byte, .i_tx_byte_valid,
      .o_tx_byte_ready, .o_tx_done, .o_rx_byte, .o_rx_byte_valid, .o_rx_start, .o_rx_end);
   always #12.5 i_clk = ~i_clk;
   always #3 i_fc_clk = ~i_fc_clk;
   task automatic close_out;
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   // Receive pulses last one cycle, so they are caught away from the launching edge.
   always @(negedge i_clk)
      rx_seen <= rx_seen | {o_rx_byte_valid, o_rx_end, o_rx_start};
   // The whole sequence needs about four hundred cycles.
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      tick(10);
      i_sys_rst = 0;
      tick(3);
      i_tune_manual = 1;
      i_tune_bits = 4'hA;
      tick(3);
      chk("tune1", 8'h0A, {4'h0, o_tune_cap_switch_pin1});
      chk("tune2", 8'h0A, {4'h0, o_tune_cap_switch_pin2});
      i_tune_manual = 0;
      tick(3);
      chk("tune_auto", 8'h05, {4'h0, o_tune_cap_switch_pin2});
      nfcs_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
      tick(6);
      chk("no_arm", 8'h00, {7'h0, o_transparent});
      nfcs_host_model_i.set_pins(1'b0, 1'b0, 1'b0);
      i_cmd_transparent = 1;
      tick(1);
      i_cmd_transparent = 0;
      nfcs_host_model_i.set_pins(1'b1, 1'b1, 1'b1);
      i_demod_am = 1;
      i_demod_pm = 1;
      tick(8);
      chk("transp", 8'h01, {7'h0, o_transparent});
      chk("tx_mod", 8'h01, {7'h0, o_tx_mod});
      chk("rx_on", 8'h01, {7'h0, o_rx_on});
      chk("miso_am", 8'h01, {7'h0, o_spi_miso});
      chk("irq_pm", 8'h01, {7'h0, o_irq});
      nfcs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
      i_demod_am = 0;
      i_rx_chan_am_en = 0;
      tick(6);
      chk("miso_one", 8'h01, {7'h0, o_spi_miso});
      chk("irq_low", 8'h00, {7'h0, o_irq});
      chk("tx_mod_off", 8'h00, {7'h0, o_tx_mod});
      chk("rx_on_sclk", 8'h01, {7'h0, o_rx_on});
      i_field_detect_enable = 1;
      i_field_det = 1;
      tick(6);
      chk("irq_fd", 8'h01, {7'h0, o_irq});
      i_cmd_start = 1;
      tick(1);
      i_cmd_start = 0;
      tick(3);
      chk("leave", 8'h00, {7'h0, o_transparent});
      i_op_ctrl = 8'h00;
      tick(3);
      chk("low_pwr", 8'h01, {7'h0, o_low_power_target});
      chk("tx_idle", 8'h00, {7'h0, o_tx_byte_ready});
      i_stream_mode = NFCS_STRM_SUBC;
      i_tx_cmd = 1;
      tick(1);
      i_tx_cmd = 0;
      chk("tx_ready", 8'h01, {7'h0, o_tx_byte_ready});
      i_tx_byte = 8'h01;
      i_tx_byte_valid = 1;
      tick(1);
      i_tx_byte_valid = 0;
      tick(28);
      chk("tx_bit0", 8'h01, {7'h0, o_tx_mod});
      tick(6);
      chk("tx_bit1", 8'h00, {7'h0, o_tx_mod});
      while (!o_tx_done && k < 300)
      begin
         tick(1);
         k++;
      end
      chk("tx_done", 8'h01, {7'h0, o_tx_done});
      chk("tx_disarm", 8'h00, {7'h0, o_tx_byte_ready});
      i_stream_mode = NFCS_STRM_BPSK;
      tick(3);
      chk("rx_quiet", 8'h00, {5'h0, rx_seen});
      repeat (40)
      begin
         i_demod_am = ~i_demod_am;
         tick(1);
      end
      tick(10);
      chk("rx_events", 8'h07, {5'h0, rx_seen});
      close_out();
   end
endmodule : nfc_stream_transparent_mode_bench
`default_nettype wire
